// >>> hdl/qcs_regs.svh
// Register map, field layout, reset values and sizes of the QoS block
`ifndef QCS_REGS_SVH
`define QCS_REGS_SVH

`define QCS_ADDR_W      12
`define QCS_ADDR_CTRL   12'h000
`define QCS_ADDR_PMAP   12'h004
`define QCS_ADDR_WGT    12'h008
`define QCS_ADDR_PEN    12'h00c
`define QCS_ADDR_STAT   12'h010
`define QCS_ADDR_PSEL   12'h014
`define QCS_ADDR_PPRI   12'h018
`define QCS_DTAB_PAGE   4'h1
`define QCS_DTAB_PG     11:8
`define QCS_DTAB_IDX    7:2

`define QCS_CTRL_W      6
`define QCS_CTRL_CMODE  1:0
`define QCS_CTRL_SMODE  3:2
`define QCS_CTRL_DSCPEN 4
`define QCS_CTRL_TSEL   5
`define QCS_CTRL_RST    6'h00
`define QCS_PMAP_RST    16'hfa50
`define QCS_WGT_RST     16'h8421
`define QCS_PEN_RST     26'h3ffffff
`define QCS_PPRI_RST    4'h8
`define QCS_PP_DIS      3
`define QCS_PP_VAL      2:0
`define QCS_STAT_W      14

`define QCS_PORTS       26
`define QCS_PORT_W      5
`define QCS_DSCP_N      64
`define QCS_TOS_DSCP    7:2
`define QCS_DESC_W      16
`define QCS_SEQ_W       5
`define QCS_Q_DEPTH     4
`define QCS_CNT_W       3

`endif

// >>> hdl/qcs_pkg.sv
// Types shared by the QoS classifier and scheduler
package qcs_pkg;
  typedef logic [1:0] qcs_class_t;
  typedef logic [2:0] qcs_prio_t;
  typedef enum logic [1:0] {
    CM_TAG  = 2'b00,
    CM_DSCP = 2'b01,
    CM_PORT = 2'b10
  } qcs_cmode_e;
  typedef enum logic [1:0] {
    SM_FCFS = 2'b00,
    SM_SP   = 2'b01,
    SM_WRR  = 2'b10
  } qcs_smode_e;
  localparam qcs_class_t CLS_LOWEST = 2'h0;
endpackage

// >>> hdl/qcs_top.sv
// QoS classifier, four egress queues and scheduler with APB registers
`timescale 1ns/10ps
`include "qcs_regs.svh"

module qcs_fifo #(
  parameter int W = 8,
  parameter int D = 4,
  parameter int CW = 3
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Fill side
  input  wire logic          wr_valid,
  output logic               wr_ready,
  input  wire logic [W-1:0]  wr_data,
  // Drain side
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic [W-1:0]       rd_data,
  // Occupancy
  output logic [CW-1:0]      count
);
  logic [W-1:0]          mem [0:D-1];
  logic [$clog2(D)-1:0]  wp_reg;
  logic [$clog2(D)-1:0]  rp_reg;
  logic [CW-1:0]         cnt_reg;
  logic                  do_wr;
  logic                  do_rd;

  assign wr_ready = (cnt_reg != CW'(D));
  assign rd_valid = (cnt_reg != '0);
  assign rd_data  = mem[rp_reg];
  assign count    = cnt_reg;
  assign do_wr    = wr_valid & wr_ready;
  assign do_rd    = rd_valid & rd_ready;

  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem[wp_reg] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (do_wr)
        wp_reg <= wp_reg + 1'b1;
      if (do_rd)
        rp_reg <= rp_reg + 1'b1;
      if (do_wr && !do_rd)
        cnt_reg <= cnt_reg + 1'b1;
      else if (do_rd && !do_wr)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

module qcs_top
  import qcs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    ce,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`QCS_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Ingress frame descriptors
  input  wire logic                    in_valid,
  output logic                         in_ready,
  input  wire logic [`QCS_PORT_W-1:0]  in_port,
  input  wire logic                    in_tagged,
  input  wire logic [2:0]              in_pcp,
  input  wire logic                    in_ipv4,
  input  wire logic [7:0]              in_tos,
  input  wire logic [`QCS_DESC_W-1:0]  in_desc,
  // Egress frame descriptors
  output logic                         out_valid,
  input  wire logic                    out_ready,
  output logic [`QCS_DESC_W-1:0]       out_desc,
  output qcs_class_t                   out_class
);
  localparam int EW = `QCS_DESC_W + `QCS_SEQ_W;

  logic [`QCS_CTRL_W-1:0]  ctrl_reg;
  logic [15:0]             pmap_reg;
  logic [15:0]             wgt_reg;
  logic [`QCS_PORTS-1:0]   pen_reg;
  logic [`QCS_PORT_W-1:0]  pidx_reg;
  logic [3:0]              pprio_mem [0:`QCS_PORTS-1];
  qcs_prio_t               dtab [0:`QCS_DSCP_N-1];
  logic [31:0]             rd_data;
  logic                    rd_err;
  logic                    wr_en;
  logic                    rd_cap_reg;
  qcs_cmode_e              cmode;
  qcs_smode_e              smode;
  logic                    dscp_en;
  logic                    tsel;
  logic [3:0]              pent;
  logic                    pen_ok;
  qcs_prio_t               prio;
  logic                    hit;
  qcs_class_t              cls;
  logic                    push;
  logic [3:0]              q_val;
  logic [3:0]              q_rdy;
  logic [EW-1:0]           q_data [0:3];
  logic [`QCS_CNT_W-1:0]   q_cnt [0:3];
  logic [`QCS_SEQ_W-1:0]   age [0:3];
  logic [`QCS_SEQ_W-1:0]   seq_reg;
  qcs_class_t              pick;
  logic                    pick_ok;
  logic                    wrr_stay;
  logic                    pop;
  qcs_class_t              wrr_cls_reg;
  logic [3:0]              wrr_cnt_reg;
  logic                    out_valid_reg;
  logic [`QCS_DESC_W-1:0]  out_desc_reg;
  qcs_class_t              out_class_reg;
  logic                    fcfs_ok;

  function automatic qcs_class_t map_class(input logic [15:0] m,
                                           input qcs_prio_t p);
    return m[p*2 +: 2];
  endfunction

  function automatic logic [3:0] weight_of(input logic [15:0] w,
                                           input qcs_class_t c);
    logic [3:0] v;
    v = w[c*4 +: 4];
    return (v == 4'h0) ? 4'h1 : v;
  endfunction

  function automatic logic [3:0] above_mask(input qcs_class_t c);
    return 4'(4'hf << (c + 3'h1));
  endfunction

  assign cmode   = qcs_cmode_e'(ctrl_reg[`QCS_CTRL_CMODE]);
  assign smode   = qcs_smode_e'(ctrl_reg[`QCS_CTRL_SMODE]);
  assign dscp_en = ctrl_reg[`QCS_CTRL_DSCPEN];
  assign tsel    = ctrl_reg[`QCS_CTRL_TSEL];

  // APB: ready waits until this transfer's read data has been taken
  assign pready  = ce & rd_cap_reg;
  assign wr_en   = psel & penable & pwrite & pready;

  always_comb
  begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (paddr == `QCS_ADDR_CTRL)
      rd_data[`QCS_CTRL_W-1:0] = ctrl_reg;
    else if (paddr == `QCS_ADDR_PMAP)
      rd_data[15:0] = pmap_reg;
    else if (paddr == `QCS_ADDR_WGT)
      rd_data[15:0] = wgt_reg;
    else if (paddr == `QCS_ADDR_PEN)
      rd_data[`QCS_PORTS-1:0] = pen_reg;
    else if (paddr == `QCS_ADDR_STAT)
      rd_data[`QCS_STAT_W-1:0] = {wrr_cls_reg, q_cnt[3], q_cnt[2],
                                  q_cnt[1], q_cnt[0]};
    else if (paddr == `QCS_ADDR_PSEL)
      rd_data[`QCS_PORT_W-1:0] = pidx_reg;
    else if (paddr == `QCS_ADDR_PPRI)
      rd_data[3:0] = (pidx_reg < `QCS_PORTS) ? pprio_mem[pidx_reg]
                                             : `QCS_PPRI_RST;
    else if (paddr[`QCS_DTAB_PG] == `QCS_DTAB_PAGE && paddr[1:0] == 2'h0)
      rd_data[2:0] = dtab[paddr[`QCS_DTAB_IDX]];
    else
      rd_err = 1'b1;
  end

  // Read data and error are taken once per transfer, normally at setup;
  // a setup cycle lost to a low ce costs one wait state instead
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata     <= '0;
      pslverr    <= 1'b0;
      rd_cap_reg <= 1'b0;
    end
    else if (ce && psel && !rd_cap_reg)
    begin
      prdata     <= pwrite ? 32'h0 : rd_data;
      pslverr    <= rd_err;
      rd_cap_reg <= 1'b1;
    end
    else if (ce && psel && penable)
      rd_cap_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg <= `QCS_CTRL_RST;
      pmap_reg <= `QCS_PMAP_RST;
      wgt_reg  <= `QCS_WGT_RST;
      pen_reg  <= `QCS_PEN_RST;
      pidx_reg <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == `QCS_ADDR_CTRL)
        ctrl_reg <= pwdata[`QCS_CTRL_W-1:0];
      else if (paddr == `QCS_ADDR_PMAP)
        pmap_reg <= pwdata[15:0];
      else if (paddr == `QCS_ADDR_WGT)
        wgt_reg <= pwdata[15:0];
      else if (paddr == `QCS_ADDR_PEN)
        pen_reg <= pwdata[`QCS_PORTS-1:0];
      else if (paddr == `QCS_ADDR_PSEL)
        pidx_reg <= pwdata[`QCS_PORT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `QCS_PORTS; i++)
        pprio_mem[i] <= `QCS_PPRI_RST;
    end
    else if (wr_en && paddr == `QCS_ADDR_PPRI && pidx_reg < `QCS_PORTS)
      pprio_mem[pidx_reg] <= pwdata[3:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `QCS_DSCP_N; i++)
        dtab[i] <= '0;
    end
    else if (wr_en && paddr[`QCS_DTAB_PG] == `QCS_DTAB_PAGE
             && paddr[1:0] == 2'h0)
      dtab[paddr[`QCS_DTAB_IDX]] <= pwdata[2:0];
  end

  // Classification; the class is fixed when the frame is queued
  assign pent   = (in_port < `QCS_PORTS) ? pprio_mem[in_port]
                                         : `QCS_PPRI_RST;
  assign pen_ok = (in_port < `QCS_PORTS) && pen_reg[in_port];

  always_comb
  begin
    prio = '0;
    hit  = 1'b0;
    case (cmode)
      CM_TAG:
      begin
        if (in_tagged)
        begin
          prio = in_pcp;
          hit  = 1'b1;
        end
        else if (tsel && !pent[`QCS_PP_DIS])
        begin
          prio = pent[`QCS_PP_VAL];
          hit  = 1'b1;
        end
      end
      CM_DSCP:
      begin
        // Precedence and service bits form the codepoint; bits 1:0 unused
        if (dscp_en && pen_ok && in_ipv4)
        begin
          prio = dtab[in_tos[`QCS_TOS_DSCP]];
          hit  = 1'b1;
        end
      end
      CM_PORT:
      begin
        if (!pent[`QCS_PP_DIS])
        begin
          prio = pent[`QCS_PP_VAL];
          hit  = 1'b1;
        end
      end
      default:
      begin
        prio = '0;
        hit  = 1'b0;
      end
    endcase
  end

  assign cls      = hit ? map_class(pmap_reg, prio) : CLS_LOWEST;
  assign in_ready = ce & q_rdy[cls];
  assign push     = in_valid & in_ready;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_q
      qcs_fifo #(
        .W  (EW),
        .D  (`QCS_Q_DEPTH),
        .CW (`QCS_CNT_W)
      ) u_fifo (
        .clk      (clk),
        .rstn     (rstn),
        .wr_valid (in_valid & ce & (cls == 2'(g))),
        .wr_ready (q_rdy[g]),
        .wr_data  ({in_desc, seq_reg}),
        .rd_valid (q_val[g]),
        .rd_ready (pop & (pick == 2'(g))),
        .rd_data  (q_data[g]),
        .count    (q_cnt[g])
      );
      assign age[g] = seq_reg - q_data[g][`QCS_SEQ_W-1:0];
    end
  endgenerate

  // Arrival stamp; at most 16 frames queued so the age never wraps under FCFS; SP or WRR can starve a queue long enough to wrap it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seq_reg <= '0;
    else if (push)
      seq_reg <= seq_reg + 1'b1;
  end

  always_comb
  begin
    pick     = CLS_LOWEST;
    pick_ok  = 1'b0;
    wrr_stay = 1'b0;
    case (smode)
      SM_FCFS:
      begin
        for (int i = 0; i < 4; i++)
          if (q_val[i] && (!pick_ok || age[i] > age[pick]))
          begin
            pick    = 2'(i);
            pick_ok = 1'b1;
          end
      end
      SM_SP:
      begin
        for (int i = 0; i < 4; i++)
          if (q_val[i])
          begin
            pick    = 2'(i);
            pick_ok = 1'b1;
          end
      end
      SM_WRR:
      begin
        if (q_val[wrr_cls_reg] &&
            wrr_cnt_reg < weight_of(wgt_reg, wrr_cls_reg))
        begin
          pick     = wrr_cls_reg;
          pick_ok  = 1'b1;
          wrr_stay = 1'b1;
        end
        else
        begin
          for (int k = 1; k <= 4; k++)
            if (!pick_ok && q_val[2'(wrr_cls_reg - 2'(k))])
            begin
              pick    = 2'(wrr_cls_reg - 2'(k));
              pick_ok = 1'b1;
            end
        end
      end
      default:
      begin
        pick_ok = 1'b0;
      end
    endcase
  end

  assign pop = ce & pick_ok & (!out_valid_reg | out_ready);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrr_cls_reg <= 2'h3;
      wrr_cnt_reg <= '0;
    end
    else if (pop && smode == SM_WRR)
    begin
      wrr_cls_reg <= pick;
      wrr_cnt_reg <= wrr_stay ? wrr_cnt_reg + 4'h1 : 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid_reg <= 1'b0;
      out_desc_reg  <= '0;
      out_class_reg <= CLS_LOWEST;
    end
    else if (ce && (!out_valid_reg || out_ready))
    begin
      out_valid_reg <= pick_ok;
      if (pick_ok)
      begin
        out_desc_reg  <= q_data[pick][EW-1:`QCS_SEQ_W];
        out_class_reg <= pick;
      end
    end
  end

  assign out_valid = out_valid_reg;
  assign out_desc  = out_desc_reg;
  assign out_class = out_class_reg;

  always_comb
  begin
    fcfs_ok = 1'b1;
    for (int i = 0; i < 4; i++)
      if (q_val[i] && age[i] > age[pick])
        fcfs_ok = 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence pop_s;
    pop;
  endsequence
  sequence deliver_s;
    out_valid_reg && out_class_reg == $past(pick)
      && out_desc_reg == $past(q_data[pick][EW-1:`QCS_SEQ_W]);
  endsequence

  untag_low_a: assert property (
    push && cmode == CM_TAG && !in_tagged && !tsel |-> cls == CLS_LOWEST)
    else $error("untagged frame not in lowest queue");
  tag_map_a: assert property (
    push && cmode == CM_TAG && in_tagged
      |-> cls == map_class(pmap_reg, in_pcp))
    else $error("tagged frame class wrong");
  dscp_off_a: assert property (
    push && cmode == CM_DSCP && !dscp_en |-> cls == CLS_LOWEST)
    else $error("dscp table used while disabled");
  dscp_port_a: assert property (
    push && cmode == CM_DSCP && !pen_ok |-> cls == CLS_LOWEST)
    else $error("dscp table used on disabled port");
  dscp_map_a: assert property (
    push && cmode == CM_DSCP && dscp_en && pen_ok && in_ipv4
      |-> cls == map_class(pmap_reg, dtab[in_tos[`QCS_TOS_DSCP]]))
    else $error("dscp lookup class wrong");
  port_mode_a: assert property (
    push && cmode == CM_PORT
      |-> cls == (pent[`QCS_PP_DIS] ? CLS_LOWEST
                  : map_class(pmap_reg, pent[`QCS_PP_VAL])))
    else $error("port priority class wrong");
  sp_order_a: assert property (
    pop && smode == SM_SP |-> (q_val & above_mask(pick)) == 4'h0)
    else $error("lower queue served before higher");
  fcfs_order_a: assert property (
    pop && smode == SM_FCFS |-> fcfs_ok)
    else $error("frame served out of arrival order");
  wrr_bound_a: assert property (
    pop && smode == SM_WRR && wrr_stay
      |-> wrr_cnt_reg < weight_of(wgt_reg, wrr_cls_reg)
      ##1 wrr_cnt_reg == $past(wrr_cnt_reg) + 4'h1)
    else $error("weighted round robin count exceeded");
  deliver_out_a: assert property (
    pop_s |=> deliver_s)
    else $error("popped frame not delivered");
  cfg_write_a: assert property (
    wr_en && paddr == `QCS_ADDR_CTRL
      |=> ctrl_reg == $past(pwdata[`QCS_CTRL_W-1:0]))
    else $error("control write not applied");
endmodule

// >>> test/qcs_sink.sv
// Egress sink model: takes descriptors, may stall or accept every other cycle
`timescale 1ns/10ps
`include "qcs_regs.svh"
module qcs_sink
  import qcs_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Egress side
  input  wire logic                   out_valid,
  output logic                        out_ready,
  input  wire logic [`QCS_DESC_W-1:0] out_desc,
  input  wire qcs_class_t             out_class,
  // Pacing
  input  wire logic                   stall,
  input  wire logic                   slow
);
  logic        phase_reg;
  logic [17:0] got[$];

  assign out_ready = !stall && (!slow || phase_reg);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase_reg <= 1'b0;
    else
    begin
      phase_reg <= !phase_reg;
      if (out_valid && out_ready)
        got.push_back({out_class, out_desc});
    end
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the QoS classifier and scheduler
`timescale 1ns/10ps
`include "qcs_regs.svh"
module testbench
  import qcs_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       tag;
    logic [2:0] pcp;
    logic       ip;
    logic [7:0] tos;
    logic [4:0] port;
    qcs_class_t cls;
  } qcs_row_s;

  logic        clk, rstn, ce, psel, penable, pwrite, pready, pslverr;
  logic        in_valid, in_ready, in_tagged, in_ipv4;
  logic        out_valid, out_ready, stall, slow, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  in_pcp;
  logic [4:0]  in_port;
  logic [7:0]  in_tos;
  logic [15:0] in_desc, out_desc;
  qcs_class_t  out_class;
  logic [17:0] exp_q[$];
  qcs_row_s    rows[12];
  logic [11:0] ra[9];
  logic [31:0] rv[9];
  int          failures, checks;

  qcs_top qcs_top_i (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_port(in_port),
    .in_tagged(in_tagged), .in_pcp(in_pcp), .in_ipv4(in_ipv4),
    .in_tos(in_tos), .in_desc(in_desc), .out_valid(out_valid),
    .out_ready(out_ready), .out_desc(out_desc), .out_class(out_class));

  qcs_sink sink_i (.clk(clk), .rstn(rstn), .out_valid(out_valid),
    .out_ready(out_ready), .out_desc(out_desc), .out_class(out_class),
    .stall(stall), .slow(slow));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task offer(input qcs_row_s r, input logic [15:0] d);
    in_valid <= 1'b1;
    in_tagged <= r.tag;
    in_pcp <= r.pcp;
    in_ipv4 <= r.ip;
    in_tos <= r.tos;
    in_port <= r.port;
    in_desc <= d;
  endtask

  task push(input qcs_row_s r, input logic [15:0] d);
    offer(r, d);
    exp_q.push_back({r.cls, d});
    do @(posedge clk); while (in_ready !== 1'b1);
  endtask

  function automatic qcs_row_s tg(input logic [2:0] p, input qcs_class_t c);
    return '{8'h00, 1'b1, p, 1'b0, 8'h00, 5'd0, c};
  endfunction

  // Releases the sink and compares everything it took, in order
  task drain;
    int n;
    n = 0;
    in_valid <= 1'b0;
    stall <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (sink_i.got.size() < exp_q.size() && n < 300);
    chk(sink_i.got.size(), exp_q.size());
    foreach (exp_q[i]) chk(sink_i.got[i], exp_q[i]);
    sink_i.got.delete();
    exp_q.delete();
    stall <= 1'b1;
  endtask

  task not_top(input logic [7:0] c);
    apb(1'b1, `QCS_ADDR_CTRL, {24'h0, c});
    push(rows[5], 16'h0200);
    exp_q.delete();
    exp_q.push_back({2'd0, 16'h0200});
    drain();
  endtask

  task do_reset;
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    sink_i.got.delete();
  endtask

  initial
  begin
    #(100 * 30000);
    failures++;
    close_out();
  end

  initial
  begin
    failures = 0;
    checks = 0;
    rstn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {in_valid, in_tagged, in_pcp, in_ipv4, in_tos, in_port, in_desc} = '0;
    stall = 1'b1;
    slow = 1'b0;
    rows[0] = '{8'h00, 1'b1, 3'd7, 1'b0, 8'h00, 5'd0, 2'd3};
    rows[1] = '{8'h00, 1'b1, 3'd4, 1'b0, 8'h00, 5'd0, 2'd2};
    rows[2] = '{8'h00, 1'b1, 3'd2, 1'b0, 8'h00, 5'd0, 2'd1};
    rows[3] = '{8'h00, 1'b1, 3'd1, 1'b1, 8'hb9, 5'd1, 2'd0};
    rows[4] = '{8'h00, 1'b0, 3'd7, 1'b0, 8'h00, 5'd0, 2'd0};
    rows[5] = '{8'h11, 1'b1, 3'd0, 1'b1, 8'hb9, 5'd1, 2'd3};
    rows[6] = '{8'h11, 1'b1, 3'd7, 1'b1, 8'h03, 5'd1, 2'd0};
    rows[7] = '{8'h11, 1'b1, 3'd7, 1'b0, 8'hb9, 5'd1, 2'd0};
    rows[8] = '{8'h02, 1'b1, 3'd0, 1'b1, 8'h00, 5'd5, 2'd3};
    rows[9] = '{8'h02, 1'b1, 3'd7, 1'b1, 8'hb9, 5'd6, 2'd0};
    rows[10] = '{8'h20, 1'b0, 3'd0, 1'b0, 8'h00, 5'd5, 2'd3};
    rows[11] = '{8'h03, 1'b1, 3'd7, 1'b0, 8'h00, 5'd0, 2'd0};
    ra = '{`QCS_ADDR_CTRL, `QCS_ADDR_PMAP, `QCS_ADDR_WGT, `QCS_ADDR_PEN,
           `QCS_ADDR_STAT, `QCS_ADDR_PSEL, `QCS_ADDR_PPRI, 12'h100, 12'h01c};
    rv = '{32'h0, 32'hfa50, 32'h8421, 32'h3ffffff, 32'h3000, 32'h0, 32'h8,
           32'h0, 32'h0};
    do_reset();
    apb(1'b1, 12'h1b8, 32'h7);
    apb(1'b1, `QCS_ADDR_PSEL, 32'h5);
    apb(1'b1, `QCS_ADDR_PPRI, 32'h6);
    apb(1'b0, `QCS_ADDR_PPRI, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, 12'h1b8, 32'h0);
    chk(rd, 32'h7);
    foreach (rows[i])
    begin
      apb(1'b1, `QCS_ADDR_CTRL, {24'h0, rows[i].ctrl});
      push(rows[i], 16'h0100 + 16'(i));
      drain();
    end
    not_top(8'h01);
    apb(1'b1, `QCS_ADDR_PEN, 32'h3fffffd);
    not_top(8'h11);
    // Scheduler switched off holds the frame in its queue
    apb(1'b1, `QCS_ADDR_CTRL, 32'hc);
    push(rows[0], 16'h0300);
    in_valid <= 1'b0;
    stall <= 1'b0;
    repeat (3) @(posedge clk);
    chk(out_valid, 1'b0);
    apb(1'b1, `QCS_ADDR_CTRL, 32'h0);
    drain();
    // Arrival order kept; a mapping change spares queued frames
    apb(1'b1, `QCS_ADDR_CTRL, 32'h0);
    push(tg(3'd0, 2'd0), 16'h0a01);
    push(tg(3'd7, 2'd3), 16'h0a02);
    push(tg(3'd2, 2'd1), 16'h0a03);
    push(tg(3'd0, 2'd0), 16'h0a04);
    in_valid <= 1'b0;
    apb(1'b1, `QCS_ADDR_PMAP, 32'h0);
    push(tg(3'd7, 2'd0), 16'h0a05);
    drain();
    apb(1'b1, `QCS_ADDR_PMAP, 32'hfa50);
    // Strict priority with the lowest queue filled until it refuses
    apb(1'b1, `QCS_ADDR_CTRL, 32'h4);
    for (int k = 0; k < 5; k++)
      push(tg(3'd0, 2'd0), 16'h0b00 + 16'(k));
    offer(tg(3'd0, 2'd0), 16'h0bff);
    @(posedge clk);
    chk(in_ready, 1'b0);
    ce <= 1'b0;
    offer(tg(3'd7, 2'd3), 16'h0b10);
    @(posedge clk);
    chk(in_ready, 1'b0);
    ce <= 1'b1;
    push(tg(3'd7, 2'd3), 16'h0b10);
    exp_q = {exp_q[0], exp_q[5], exp_q[1], exp_q[2], exp_q[3], exp_q[4]};
    drain();
    // Read whose setup cycle falls while the clock enable is low
    fork
      apb(1'b0, `QCS_ADDR_PMAP, 32'h0);
      begin
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk(rd, 32'hfa50);
    // Reset values, unmapped access, then weighted round robin
    do_reset();
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
      chk(er, i == 8);
    end
    apb(1'b1, `QCS_ADDR_CTRL, 32'h8);
    apb(1'b1, `QCS_ADDR_WGT, 32'h2111);
    for (int k = 0; k < 4; k++)
      push(tg(3'd7, 2'd3), 16'h0c00 + 16'(k));
    push(tg(3'd0, 2'd0), 16'h0c10);
    push(tg(3'd0, 2'd0), 16'h0c11);
    exp_q = {exp_q[0], exp_q[1], exp_q[4], exp_q[2], exp_q[3], exp_q[5]};
    slow <= 1'b1;
    drain();
    close_out();
  end
endmodule
